// ===== tws_master.v
// two-wire master sequencer with apb register access
// Behaviour
// - after data acked, loaded byte with flag clear is sent, ack sampled
// - after data nacked, same four continuations as after data acked
// - flag clear with start only issues repeated start
// - flag clear with stop only sends stop, hardware clears stop request
// - start and stop both set: stop, then start, stop request cleared
// - arbitration lost, start low: release bus, return to idle
// - arbitration lost, start high: wait for free bus then start
// - master work begins with start; address read bit picks direction
// - start condition generated as soon as bus is free
// - after start sent, flag set and start status reported
// - after read address exchanged, flag set with arb, ack or nack status
// - received byte readable in data register while flag set
// - last received byte answered with nack via cleared ack enable
// - after repeated start any slave and direction may follow
// - flag cleared by writing one, zero leaves it
// - interface works only while enable bit is one
// - data write while flag low discarded, write collision set
// - transfer held while flag set
// - receive byte acked when ack enable is one, else nacked
`timescale 1ns/100ps
`include "tws_consts.vh"
module tws_master (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output wire PSLVERR,
  output reg [31:0] PRDATA,
  // two-wire bus, oe low drives the wire low
  input wire SCL_IN,
  output wire SCL_OUT,
  output wire SCL_OE_N,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE_N,
  // interrupt request
  output wire IRQ
);
  localparam M_IDLE = 7'b0000001;
  localparam M_STA = 7'b0000010;
  localparam M_ADR = 7'b0000100;
  localparam M_DAT = 7'b0001000;
  localparam M_STO = 7'b0010000;
  localparam M_HOLD = 7'b0100000;
  localparam M_STS = 7'b1000000;
  reg [6:0] m_q;
  reg [7:0] ctrl_q;
  reg [4:0] stat_q;
  reg [7:0] data_q;
  reg [7:0] prsc_q;
  reg [7:0] div_q;
  reg tick_q;
  reg rd_q;
  reg busy_q;
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg scl_d1_q;
  reg sda_d1_q;
  reg cmd_sta_q;
  reg cmd_sto_q;
  reg cmd_byte_q;
  reg set_flag;
  reg [4:0] new_stat;
  wire scl_s;
  wire sda_s;
  wire wr;
  wire rd;
  wire en;
  wire flag;
  wire e_done;
  wire e_arb;
  wire e_ack;
  wire [7:0] e_rx;
  wire scl_oe_n;
  wire sda_oe_n;
  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction
  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & ~PWRITE;
  assign en = ctrl_q[`TWS_B_EN];
  assign flag = ctrl_q[`TWS_B_FLAG];
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign scl_s = scl_s_q[1];
  assign sda_s = sda_s_q[1];
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  // disabled interface lets go of both wires
  assign SCL_OE_N = scl_oe_n | ~en;
  assign SDA_OE_N = sda_oe_n | ~en;
  assign IRQ = flag & ctrl_q[`TWS_B_IE];
  // two-flop synchronisers; the second stage feeds all logic
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], SCL_IN};
      sda_s_q <= {sda_s_q[0], SDA_IN};
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end
  // bus busy between a start and a stop seen on the wires
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      busy_q <= 1'b0;
    end else if (scl_s && scl_d1_q && sda_d1_q && !sda_s) begin
      busy_q <= 1'b1;
    end else if (scl_s && scl_d1_q && !sda_d1_q && sda_s) begin
      busy_q <= 1'b0;
    end
  end
  // quarter bit tick divider
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q >= prsc_q) begin
      div_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end
  // status produced by a finished engine step
  always @* begin
    set_flag = 1'b0;
    new_stat = stat_q;
    if (e_done) begin
      if (m_q == M_STA) begin
        set_flag = 1'b1;
        new_stat = (stat_q == `TWS_ST_IDLE) ? `TWS_ST_START : `TWS_ST_RSTART;
      end else if (m_q == M_ADR) begin
        set_flag = 1'b1;
        if (e_arb) begin
          new_stat = `TWS_ST_ARB;
        end else if (rd_q) begin
          new_stat = e_ack ? `TWS_ST_AR_NACK : `TWS_ST_AR_ACK;
        end else begin
          new_stat = e_ack ? `TWS_ST_AW_NACK : `TWS_ST_AW_ACK;
        end
      end else if (m_q == M_DAT) begin
        set_flag = 1'b1;
        if (e_arb) begin
          new_stat = `TWS_ST_ARB;
        end else if (rd_q) begin
          new_stat = e_ack ? `TWS_ST_DR_NACK : `TWS_ST_DR_ACK;
        end else begin
          new_stat = e_ack ? `TWS_ST_DT_NACK : `TWS_ST_DT_ACK;
        end
      end
    end
  end
  // sequencer and registers
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      m_q <= M_IDLE;
      ctrl_q <= `TWS_CTRL_RST;
      stat_q <= `TWS_ST_IDLE;
      data_q <= `TWS_DATA_RST;
      prsc_q <= `TWS_PRSC_RST;
      rd_q <= 1'b0;
      cmd_sta_q <= 1'b0;
      cmd_sto_q <= 1'b0;
      cmd_byte_q <= 1'b0;
    end else begin
      if (wr && is_addr(PADDR, `TWS_ADDR_CTRL)) begin
        ctrl_q[`TWS_B_ACK] <= PWDATA[`TWS_B_ACK];
        ctrl_q[`TWS_B_STA] <= PWDATA[`TWS_B_STA];
        ctrl_q[`TWS_B_STO] <= PWDATA[`TWS_B_STO];
        ctrl_q[`TWS_B_EN] <= PWDATA[`TWS_B_EN];
        ctrl_q[`TWS_B_IE] <= PWDATA[`TWS_B_IE];
        if (PWDATA[`TWS_B_FLAG] && !set_flag) begin
          ctrl_q[`TWS_B_FLAG] <= 1'b0;
        end
      end else if (wr && is_addr(PADDR, `TWS_ADDR_DATA)) begin
        if (flag) begin
          data_q <= PWDATA[7:0];
          ctrl_q[`TWS_B_WC] <= 1'b0;
        end else begin
          ctrl_q[`TWS_B_WC] <= 1'b1;
        end
      end else if (wr && is_addr(PADDR, `TWS_ADDR_PRSC)) begin
        prsc_q <= PWDATA[7:0];
      end
      if (set_flag) begin
        ctrl_q[`TWS_B_FLAG] <= 1'b1;
        stat_q <= new_stat;
        cmd_byte_q <= 1'b0;
        cmd_sta_q <= 1'b0;
        if (m_q == M_DAT && rd_q) begin
          data_q <= e_rx;
        end
        m_q <= M_HOLD;
      end
      if (!en) begin
        m_q <= M_IDLE;
        stat_q <= `TWS_ST_IDLE;
        cmd_sta_q <= 1'b0;
        cmd_sto_q <= 1'b0;
        cmd_byte_q <= 1'b0;
      end else begin
        case (m_q)
          M_IDLE: if (!flag && ctrl_q[`TWS_B_STA] && !busy_q) begin
            m_q <= M_STA;
            cmd_sta_q <= 1'b1;
          end
          M_HOLD: if (!flag) begin
            // flag cleared by software: pick the continuation
            if (ctrl_q[`TWS_B_STO] && stat_q != `TWS_ST_ARB) begin
              m_q <= M_STO;
              cmd_sto_q <= 1'b1;
            end else if (stat_q == `TWS_ST_ARB) begin
              m_q <= M_IDLE;
              // bus was lost, so a later start is a fresh one, not a repeated one
              stat_q <= `TWS_ST_IDLE;
            end else if (ctrl_q[`TWS_B_STA]) begin
              m_q <= M_STA;
              cmd_sta_q <= 1'b1;
            end else if (stat_q == `TWS_ST_START || stat_q == `TWS_ST_RSTART) begin
              rd_q <= data_q[0];
              m_q <= M_ADR;
              cmd_byte_q <= 1'b1;
            end else if (stat_q == `TWS_ST_AR_ACK || stat_q == `TWS_ST_DR_ACK) begin
              m_q <= M_DAT;
              cmd_byte_q <= 1'b1;
            end else if (stat_q == `TWS_ST_AW_ACK || stat_q == `TWS_ST_AW_NACK ||
                         stat_q == `TWS_ST_DT_ACK || stat_q == `TWS_ST_DT_NACK) begin
              m_q <= M_DAT;
              cmd_byte_q <= 1'b1;
            end
          end
          M_STO: if (e_done) begin
            cmd_sto_q <= 1'b0;
            ctrl_q[`TWS_B_STO] <= 1'b0;
            stat_q <= `TWS_ST_IDLE;
            // start still requested: follow stop with a fresh start
            m_q <= M_IDLE;
          end
          default: begin
          end
        endcase
      end
    end
  end
  // read mux
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
    end else if (rd && !PENABLE) begin
      if (is_addr(PADDR, `TWS_ADDR_CTRL)) begin
        PRDATA <= {24'h000000, ctrl_q};
      end else if (is_addr(PADDR, `TWS_ADDR_STAT)) begin
        // prescaler field reads as zero in the low bits
        PRDATA <= {24'h000000, stat_q, 3'h0};
      end else if (is_addr(PADDR, `TWS_ADDR_DATA)) begin
        PRDATA <= {24'h000000, data_q};
      end else if (is_addr(PADDR, `TWS_ADDR_PRSC)) begin
        PRDATA <= {24'h000000, prsc_q};
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end
  tws_bit_engine u_eng (
    .clk(CORE_CLK),
    .rst(RESET),
    .tick(tick_q),
    .cmd_start(cmd_sta_q),
    .cmd_stop(cmd_sto_q),
    .cmd_byte(cmd_byte_q),
    .rd_mode(rd_q & (m_q == M_DAT)),
    .ack_out(~ctrl_q[`TWS_B_ACK]),
    .tx_byte(data_q),
    .done(e_done),
    .arb_lost(e_arb),
    .rx_byte(e_rx),
    .ack_in(e_ack),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n)
  );
endmodule

// ===== tws_consts.vh
// constants for the two-wire master sequencer
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
// register byte addresses on the apb bus
`define TWS_ADDR_CTRL 8'h00
`define TWS_ADDR_STAT 8'h04
`define TWS_ADDR_DATA 8'h08
`define TWS_ADDR_PRSC 8'h0c
// control register bit positions
`define TWS_B_FLAG 7
`define TWS_B_ACK 6
`define TWS_B_STA 5
`define TWS_B_STO 4
`define TWS_B_WC 3
`define TWS_B_EN 2
`define TWS_B_RSV 1
`define TWS_B_IE 0
// status codes, prescaler bits masked to zero
`define TWS_ST_START 5'h01
`define TWS_ST_RSTART 5'h02
`define TWS_ST_AW_ACK 5'h03
`define TWS_ST_AW_NACK 5'h04
`define TWS_ST_DT_ACK 5'h05
`define TWS_ST_DT_NACK 5'h06
`define TWS_ST_ARB 5'h07
`define TWS_ST_AR_ACK 5'h08
`define TWS_ST_AR_NACK 5'h09
`define TWS_ST_DR_ACK 5'h0a
`define TWS_ST_DR_NACK 5'h0b
`define TWS_ST_IDLE 5'h1f
// reset values
`define TWS_CTRL_RST 8'h00
`define TWS_STAT_RST 8'hf8
`define TWS_PRSC_RST 8'h04
`define TWS_DATA_RST 8'hff
// bit counter: data bits 0 to 7, then the acknowledge slot
`define TWS_LAST_BIT 4'h7
`define TWS_ACK_SLOT 4'h8
`endif

// ===== tws_bit_engine.v
// bit level engine: start, stop, byte shift and acknowledge on the two wires
`timescale 1ns/100ps
`include "tws_consts.vh"
module tws_bit_engine (
  // clock and reset
  input wire clk,
  input wire rst,
  // quarter bit tick
  input wire tick,
  // command
  input wire cmd_start,
  input wire cmd_stop,
  input wire cmd_byte,
  input wire rd_mode,
  input wire ack_out,
  input wire [7:0] tx_byte,
  // result
  output reg done,
  output reg arb_lost,
  output reg [7:0] rx_byte,
  output reg ack_in,
  // synchronised wire levels
  input wire scl_in,
  input wire sda_in,
  // line drive: oe low pulls the wire low
  output reg scl_oe_n,
  output reg sda_oe_n
);
  localparam S_IDLE = 6'b000001;
  localparam S_STA = 6'b000010;
  localparam S_STO = 6'b000100;
  localparam S_BIT = 6'b001000;
  localparam S_DONE = 6'b010000;
  localparam S_WAIT = 6'b100000;
  reg [5:0] st_q;
  reg [1:0] ph_q;
  reg [3:0] cnt_q;
  reg [8:0] sh_q;
  wire drive_bit;
  // bit 8 is the level driven in the current bit slot; the acknowledge reaches it last
  assign drive_bit = sh_q[8];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      ph_q <= 2'h0;
      cnt_q <= 4'h0;
      sh_q <= 9'h1ff;
      done <= 1'b0;
      arb_lost <= 1'b0;
      rx_byte <= 8'h00;
      ack_in <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          arb_lost <= 1'b0;
          ph_q <= 2'h0;
          if (cmd_start) begin
            st_q <= S_STA;
          end else if (cmd_stop) begin
            st_q <= S_STO;
          end else if (cmd_byte) begin
            cnt_q <= 4'h0;
            // receiver leaves data lines released, drives ack slot
            sh_q <= rd_mode ? {8'hff, ack_out} : {tx_byte, 1'b1};
            st_q <= S_BIT;
          end
        end
        S_STA: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_oe_n <= 1'b1;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: sda_oe_n <= 1'b0;
            default: begin
              scl_oe_n <= 1'b0;
              st_q <= S_DONE;
            end
          endcase
        end
        S_STO: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_oe_n <= 1'b0;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: sda_oe_n <= 1'b1;
            default: st_q <= S_DONE;
          endcase
        end
        S_BIT: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_oe_n <= drive_bit;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: begin
              // released high but seen low: another master won
              if (drive_bit && !sda_in && !rd_mode && cnt_q != `TWS_ACK_SLOT) begin
                arb_lost <= 1'b1;
              end
              if (cnt_q == `TWS_ACK_SLOT) begin
                ack_in <= sda_in;
              end else begin
                rx_byte <= {rx_byte[6:0], sda_in};
              end
            end
            default: begin
              scl_oe_n <= 1'b0;
              sh_q <= {sh_q[7:0], 1'b1};
              if (arb_lost) begin
                sda_oe_n <= 1'b1;
                scl_oe_n <= 1'b1;
                st_q <= S_DONE;
              end else if (cnt_q == `TWS_ACK_SLOT) begin
                st_q <= S_DONE;
              end else begin
                cnt_q <= cnt_q + 4'h1;
                if (rd_mode && cnt_q == `TWS_LAST_BIT) begin
                  sh_q <= {ack_out, 8'hff};
                end
              end
            end
          endcase
        end
        S_DONE: begin
          done <= 1'b1;
          st_q <= S_WAIT;
        end
        default: if (!cmd_start && !cmd_stop && !cmd_byte) begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tws_master_properties.sv
// port checker for the two-wire master sequencer
`timescale 1ns/100ps
module tws_master_chk (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET,
  // apb
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [31:0] PRDATA,
  // wires and interrupt
  input wire SCL_OUT,
  input wire SCL_OE_N,
  input wire SDA_OUT,
  input wire SDA_OE_N,
  input wire IRQ
);
  wire wr_ctrl = PSEL && PENABLE && PWRITE && PADDR == 8'h00;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  chk_zero_wait: assert property (PSEL && PENABLE |-> PREADY && !PSLVERR)
    else $error("apb access not answered at once");
  chk_rdata_upper: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_wire_low: assert property (!SCL_OUT && !SDA_OUT)
    else $error("wire output level not low");
  chk_hold_flag: assert property (
    IRQ && $past(IRQ) |-> $stable(SCL_OE_N) && $stable(SDA_OE_N))
    else $error("bus moved while flag set");
  chk_irq_mask: assert property (wr_ctrl && !PWDATA[0] |=> !IRQ)
    else $error("irq with irq enable low");
  chk_flag_keep: assert property (
    wr_ctrl && IRQ && !PWDATA[7] && PWDATA[2] && PWDATA[0] |=> IRQ)
    else $error("flag cleared by writing zero");
  chk_disable_free: assert property (
    wr_ctrl && !PWDATA[2] |-> ##[1:4] SCL_OE_N && SDA_OE_N)
    else $error("wires held while disabled");
  chk_start_order: assert property ($fell(SDA_OE_N) && SCL_OE_N |=> SCL_OE_N)
    else $error("clock pulled with start");
  chk_stop_issue: assert property (
    wr_ctrl && IRQ && PWDATA[7:4] == 4'h9 && PWDATA[2]
    |-> ##[1:600] $rose(SDA_OE_N) && SCL_OE_N)
    else $error("stop not sent");
  chk_restart: assert property (
    wr_ctrl && IRQ && PWDATA[7] && PWDATA[5] && PWDATA[2]
    |-> ##[1:800] $fell(SDA_OE_N) && SCL_OE_N)
    else $error("start not sent");
  cover property (wr_ctrl && IRQ && PWDATA[5:4] == 2'b11);
  cover property ($rose(IRQ));
  cover property ($fell(SDA_OE_N) && SCL_OE_N);
endmodule

bind tws_master tws_master_chk tws_master_chk_i (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PRDATA(PRDATA), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .IRQ(IRQ));

// ===== tws_slave_model.sv
// behavioural slave on the two-wire bus, answers one address
`timescale 1ns/100ps
module tws_slave_model #(
  parameter [6:0] ADDR = 7'h2a
) (
  // bus wires
  input wire scl,
  input wire sda,
  output reg sda_oe_n,
  // test control and observation
  input wire nack_wr,
  output reg [7:0] got,
  output reg mack
);
  reg [3:0] n = 4'h0;
  reg [7:0] sh = 8'h00;
  reg [7:0] tx = 8'ha5;
  reg act = 1'b0;
  reg adr = 1'b0;
  reg rd = 1'b0;
  reg sel = 1'b0;
  initial begin
    sda_oe_n = 1'b1;
    got = 8'h00;
    mack = 1'b1;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    adr = 1'b1;
    // the clock fall that closes the start wraps the count to zero
    n = 4'hf;
    sda_oe_n = 1'b1;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sda_oe_n = 1'b1;
  end
  always @(posedge scl) if (act) begin
    if (n < 4'h8) sh = {sh[6:0], sda};
    else if (rd && !adr) mack = sda;
  end
  // changes only while the clock is low, so it never fakes a start or stop
  always @(negedge scl) if (act) begin
    n = n + 4'h1;
    if (n == 4'h8) begin
      sda_oe_n = 1'b1;
      if (adr) begin
        rd = sh[0];
        sel = (sh[7:1] == ADDR);
        sda_oe_n = !sel;
      end else if (!rd) begin
        got = sh;
        sda_oe_n = nack_wr;
      end
    end else if (n == 4'h9) begin
      n = 4'h0;
      sda_oe_n = 1'b1;
      if (!sel) act = 1'b0;
      else if (rd && (adr || !mack)) begin
        if (!adr) tx = ~tx;
        sda_oe_n = tx[7];
      end
      adr = 1'b0;
    end else if (rd && !adr && sel) sda_oe_n = tx[4'd7 - n];
  end
endmodule

// ===== tws_master_tb.sv
// self-checking bench for the two-wire master sequencer
`timescale 1ns/100ps
module tws_master_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg pull = 1'b0;
  reg nack_wr = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [7:0] d;
  wire pready, pslverr, scl_oe_n, sda_oe_n, s_oe_n, irq, mack;
  wire [31:0] prdata;
  wire [7:0] got;
  // open-drain wires with pull-ups; pull plays a rival master
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & s_oe_n & !pull;
  integer n_fail = 0;
  integer compares = 0;
  always #2.5 clk = ~clk;
  tws_master tws_master_i (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
    .PRDATA(prdata), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_N(scl_oe_n), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE_N(sda_oe_n), .IRQ(irq));
  tws_slave_model tws_slave_model_i (.scl(scl), .sda(sda), .sda_oe_n(s_oe_n),
    .nack_wr(nack_wr), .got(got), .mack(mack));
  task chk(input [7:0] g, input [7:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [7:0] wd);
    begin
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      d = prdata[7:0];
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      apb(1'b0, a, 8'h00);
      chk(d & m, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    apb(1'b1, a, v);
  endtask
  task flag;
    integer i;
    begin
      i = 0;
      @(posedge clk);
      while (irq !== 1'b1 && i < 4000) begin
        @(posedge clk);
        i = i + 1;
      end
      chk({7'h0, irq}, 8'h01);
    end
  endtask
  // masked status compare after a control write
  task step(input [7:0] c, input [7:0] e);
    begin
      wr(8'h00, c);
      flag;
      rd(8'h04, 8'hf8, e);
    end
  endtask
  task conclude;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 8'hff, 8'h00);
    rd(8'h04, 8'hff, 8'hf8);
    rd(8'h08, 8'hff, 8'hff);
    rd(8'h0c, 8'hff, 8'h04);
    rd(8'h10, 8'hff, 8'h00);
    wr(8'h0c, 8'h03);
    wr(8'h00, 8'h05);
    wr(8'h08, 8'h77);
    rd(8'h08, 8'hff, 8'hff);
    rd(8'h00, 8'h08, 8'h08);
    step(8'ha5, 8'h08);
    wr(8'h00, 8'h05);
    rd(8'h00, 8'h80, 8'h80);
    chk({7'h0, irq}, 8'h01);
    wr(8'h08, 8'h54);
    step(8'h85, 8'h18);
    wr(8'h08, 8'h3c);
    step(8'h85, 8'h28);
    chk(got, 8'h3c);
    nack_wr <= 1'b1;
    wr(8'h08, 8'hc3);
    step(8'h85, 8'h30);
    wr(8'h08, 8'h96);
    step(8'h85, 8'h30);
    chk(got, 8'h96);
    nack_wr <= 1'b0;
    step(8'ha5, 8'h10);
    wr(8'h08, 8'h55);
    step(8'h85, 8'h40);
    step(8'hc5, 8'h50);
    rd(8'h08, 8'hff, 8'ha5);
    chk({7'h0, mack}, 8'h00);
    step(8'h85, 8'h58);
    rd(8'h08, 8'hff, 8'h5a);
    chk({7'h0, mack}, 8'h01);
    step(8'hb5, 8'h08);
    rd(8'h00, 8'h10, 8'h00);
    wr(8'h00, 8'h95);
    d = 8'h10;
    while (d[4] && compares < 10000) apb(1'b0, 8'h00, 8'h00);
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    step(8'ha5, 8'h08);
    wr(8'h08, 8'h54);
    pull <= 1'b1;
    step(8'h85, 8'h38);
    pull <= 1'b0;
    step(8'ha5, 8'h08);
    wr(8'h08, 8'h54);
    pull <= 1'b1;
    step(8'h85, 8'h38);
    pull <= 1'b0;
    wr(8'h00, 8'h85);
    rd(8'h00, 8'h80, 8'h00);
    chk({5'h0, irq, scl_oe_n, sda_oe_n}, 8'h03);
    wr(8'h00, 8'ha1);
    rd(8'h04, 8'hf8, 8'hf8);
    chk({5'h0, irq, scl_oe_n, sda_oe_n}, 8'h03);
    wr(8'h00, 8'h00);
    conclude;
  end
endmodule
